// ---- rtl/dsw_write_port.v ----
// write port, byte selects and shared address input of a burst memory core
`timescale 1ns/1ps
`include "dsw_map.vh"

module dsw_write_port #(
   parameter DATA_W = `DSW_DATA_W,
   parameter BYTE_W = `DSW_BYTE_W,
   parameter NSEL = 4,
   parameter ADDR_W = `DSW_ADDR_W,
   parameter DEPTH = `DSW_DEPTH
) (
   input wire clk,
   input wire sys_rst,
   input wire writePortSelectN,
   input wire readPortSelectN,
   input wire [ADDR_W-1:0] addrIn,
   input wire [DATA_W-1:0] dataRise,
   input wire [DATA_W-1:0] dataFall,
   input wire [NSEL-1:0] byteSelRiseN,
   input wire [NSEL-1:0] byteSelFallN,
   output wire rdValid,
   input wire rdReady,
   output wire [DATA_W-1:0] rdData,
   output reg writeBusy,
   output reg readBusy
);
   // clk stands for the positive input clock; the negative clock's beat arrives
   // on its own ports, already retimed, so both beats of a cycle land together
   //
   // write timeline, counted in clk edges from the edge that first sees the pin:
   //   edge 1  select and first beats enter the first synchroniser stage
   //   edge 2  they reach the second stage; wrStart is now high
   //   edge 3  beats 0 and 1 stored, phase two begins, writeBusy rises
   //   edge 4  beats 2 and 3 stored from the next cycle's pins, writeBusy falls
   // read timeline:
   //   edge 2  rdStart is high
   //   edge 3  burst counter loaded with four, readBusy rises
   //   edge 4  first word pushed, rdValid rises after it
   //   edge 5  on, one word per cycle while the sink is ready
   //   the buffer holds two words, so a stall costs no word
   //
   // limitation: the synchronisers add two cycles of latency to every request;
   // a part sampling its pins directly on both clock edges has none of it
   //
   // trade-off: read and write starts in one cycle are resolved in favour of
   // the write, since the controller is expected to alternate them anyway
   //
   // the address is cut to the low bits that index DEPTH words; the remaining
   // address bits are carried on the port but do not reach the arrays
   localparam IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // four arrays, one word of each per external address
   // no reset on the arrays: contents are undefined until first written
   reg [DATA_W-1:0] mem0 [0:DEPTH-1];
   reg [DATA_W-1:0] mem1 [0:DEPTH-1];
   reg [DATA_W-1:0] mem2 [0:DEPTH-1];
   reg [DATA_W-1:0] mem3 [0:DEPTH-1];

   // pin synchronisers, two stages each; select, data and byte selects share
   // the same depth, so every beat stays paired with its selects
   // reset values match the idle pin levels: selects high, data low
   wire wpsS2b;
   wire rpsS2;
   wire [ADDR_W-1:0] addrS2;
   wire [DATA_W-1:0] dRS2;
   wire [DATA_W-1:0] dFS2;
   wire [NSEL-1:0] bRS2;
   wire [NSEL-1:0] bFS2;
   dsw_sync2 #(.W(1), .RST_VAL(1'b1)) wps_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(writePortSelectN),
      .syncOut(wpsS2b)
   );
   dsw_sync2 #(.W(1), .RST_VAL(1'b1)) rps_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(readPortSelectN),
      .syncOut(rpsS2)
   );
   dsw_sync2 #(.W(ADDR_W), .RST_VAL({ADDR_W{1'b0}})) addr_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(addrIn),
      .syncOut(addrS2)
   );
   dsw_sync2 #(.W(DATA_W), .RST_VAL({DATA_W{1'b0}})) rise_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(dataRise),
      .syncOut(dRS2)
   );
   dsw_sync2 #(.W(DATA_W), .RST_VAL({DATA_W{1'b0}})) fall_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(dataFall),
      .syncOut(dFS2)
   );
   dsw_sync2 #(.W(NSEL), .RST_VAL({NSEL{1'b1}})) bsr_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(byteSelRiseN),
      .syncOut(bRS2)
   );
   dsw_sync2 #(.W(NSEL), .RST_VAL({NSEL{1'b1}})) bsf_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(byteSelFallN),
      .syncOut(bFS2)
   );

   // index into the arrays from the synchronised address
   wire [IDX_W-1:0] addrIdx = addrS2[IDX_W-1:0];
   // write burst: beats 0,1 in the start cycle, 2,3 in the next
   reg wrPhase_q;
   reg [IDX_W-1:0] wrAddr_q;
   // a start is refused while phase two runs, so bursts never overlap
   wire wrStart = ~wpsS2b & ~wrPhase_q;
   wire [IDX_W-1:0] wrIdx = wrPhase_q ? wrAddr_q : addrIdx;
   wire [DATA_W-1:0] mR;
   wire [DATA_W-1:0] mF;
   // one mask per beat, built from the selects that travelled with it
   dsw_lane_mask #(.DATA_W(DATA_W), .BYTE_W(BYTE_W), .NSEL(NSEL)) mask_rise_inst (
      .selN(bRS2),
      .mask(mR)
   );
   dsw_lane_mask #(.DATA_W(DATA_W), .BYTE_W(BYTE_W), .NSEL(NSEL)) mask_fall_inst (
      .selN(bFS2),
      .mask(mF)
   );

   // masked store; a deselected port starts no write, but phase two still stores beats 2 and 3
   always @(posedge clk) begin
      if (wrStart) begin
         mem0[wrIdx] <= (mem0[wrIdx] & ~mR) | (dRS2 & mR);
         mem1[wrIdx] <= (mem1[wrIdx] & ~mF) | (dFS2 & mF);
      end else if (wrPhase_q) begin
         mem2[wrIdx] <= (mem2[wrIdx] & ~mR) | (dRS2 & mR);
         mem3[wrIdx] <= (mem3[wrIdx] & ~mF) | (dFS2 & mF);
      end
   end

   // address latched only when a port is selected
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPhase_q <= 1'b0;
         wrAddr_q <= {IDX_W{1'b0}};
         writeBusy <= 1'b0;
      end else begin
         wrPhase_q <= wrStart;
         writeBusy <= wrStart;
         if (wrStart) begin
            wrAddr_q <= addrIdx;
         end
      end
   end

   // read: four words pushed into a two-entry buffer, stalls on back-pressure
   reg [2:0] rdCnt_q;
   reg [IDX_W-1:0] rdAddr_q;
   wire bufInReady;
   wire rdStart = ~rpsS2 & (rdCnt_q == 3'd0) & ~wrStart;
   wire pushV = (rdCnt_q != 3'd0);
   // beat index counts up as the counter falls; worked at three bits so the
   // burst length itself fits before the cut
   wire [2:0] beatFull = 3'd`DSW_BURST_LEN - rdCnt_q;
   wire [1:0] beat = beatFull[1:0];
   reg [DATA_W-1:0] pushD;
   // word select by beat number; the array index comes from the captured address
   always @* begin
      case (beat)
         2'd0: pushD = mem0[rdAddr_q];
         2'd1: pushD = mem1[rdAddr_q];
         2'd2: pushD = mem2[rdAddr_q];
         default: pushD = mem3[rdAddr_q];
      endcase
   end
   // burst counter: loaded on a start, counts down one per accepted push
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdCnt_q <= 3'd0;
         rdAddr_q <= {IDX_W{1'b0}};
         readBusy <= 1'b0;
      end else begin
         readBusy <= (rdCnt_q != 3'd0) || rdStart;
         if (rdStart) begin
            rdCnt_q <= 3'd`DSW_BURST_LEN;
            rdAddr_q <= addrIdx;
         end else if (pushV && bufInReady) begin
            rdCnt_q <= rdCnt_q - 3'd1;
         end
      end
   end

   // two-entry buffer between the burst reader and the sink
   dsw_buf2 #(.W(DATA_W)) rd_buf_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .inValid(pushV),
      .inReady(bufInReady),
      .inData(pushD),
      .outValid(rdValid),
      .outReady(rdReady),
      .outData(rdData)
   );
endmodule

// two-flop synchroniser for one pin group; only the second stage is read
module dsw_sync2 #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire clk,
   input wire sys_rst,
   input wire [W-1:0] pinIn,
   output wire [W-1:0] syncOut
);
   // first stage may go metastable; nothing but the second stage reads it
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   // a multi-bit group is only safe here because the pins hold for a cycle
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
      end else begin
         s1_q <= pinIn;
         s2_q <= s1_q;
      end
   end
   assign syncOut = s2_q;
endmodule

// expands active-low byte selects into a per-bit write mask
module dsw_lane_mask #(
   parameter DATA_W = 36,
   parameter BYTE_W = 9,
   parameter NSEL = 4
) (
   input wire [NSEL-1:0] selN,
   output wire [DATA_W-1:0] mask
);
   genvar i;
   // pure wiring, no state
   // bit i belongs to lane i / BYTE_W; 4-bit lanes give the 8-bit layout
   generate
      for (i = 0; i < DATA_W; i = i + 1) begin : g_bit
         assign mask[i] = ~selN[i / BYTE_W];
      end
   endgenerate
endmodule

// two-entry buffer with valid and ready on both sides; a stalled sink loses no word
module dsw_buf2 #(
   parameter W = 36
) (
   input wire clk,
   input wire sys_rst,
   input wire inValid,
   output wire inReady,
   input wire [W-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [W-1:0] outData
);
   // entries are plain flops, written in turn by the write pointer
   reg [W-1:0] ent0_q;
   reg [W-1:0] ent1_q;
   reg [1:0] cnt_q;
   reg wp_q;
   reg rp_q;
   // handshakes complete when valid and ready meet at the edge
   wire doPush = inValid & inReady;
   wire doPop = outValid & outReady;
   // ready looks only at the count, so it never waits on the sink's ready;
   // a push into a full buffer is never accepted
   assign inReady = (cnt_q != 2'd2);
   assign outValid = (cnt_q != 2'd0);
   // the sink sees the head entry straight from its flop
   assign outData = rp_q ? ent1_q : ent0_q;
   // push and pop in one cycle leave the count unchanged
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 2'd0;
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         ent0_q <= {W{1'b0}};
         ent1_q <= {W{1'b0}};
      end else begin
         if (doPush && !wp_q) begin
            ent0_q <= inData;
         end
         if (doPush && wp_q) begin
            ent1_q <= inData;
         end
         if (doPush) begin
            wp_q <= ~wp_q;
         end
         if (doPop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, doPush} - {1'b0, doPop};
      end
   end
endmodule

// ---- common/dsw_map.vh ----
// constants for the double-data-rate burst memory write port and address input
// What this block does
// - data of both input clock edges captured, both beats sampled on the positive edge from separate ports
// - write select active low, rising edge only
// - write select asserted starts a write; the code refuses it while phase two of a running write burst runs
// - deselected write port starts no write; only phase two of a running burst stores beats 2 and 3
// - byte selects of both edges sampled on the positive edge, pick bytes
// - byte selects travel with their data beat
// - deselected byte keeps previous memory contents
// - address sampled on positive clock rising edge
// - one address bus shared by read, write
// - four arrays, address picks four words
// - address width 19, 18 or 17 bits; the code fixes DSW_ADDR_W at 17
// - address ignored while its port deselected
// - read select active low starts read; the code refuses it beside a write start or while a read burst still runs
// - each read is burst of four words
// - accesses begin only on positive clock edge
`ifndef DSW_MAP_VH
`define DSW_MAP_VH
`define DSW_BURST_LEN 4
`define DSW_BEAT_W 2
`define DSW_DATA_W 36
`define DSW_BYTE_W 9
`define DSW_NIB_W 4
`define DSW_ADDR_W 17
`define DSW_DEPTH 16
`endif

// ---- bench/dsw_chk.sv ----
// assertions on the write port and read buffer pins
`timescale 1ns/1ps
module dsw_chk #(parameter DATA_W = 36) (
   input wire clk,
   input wire sys_rst,
   input wire writePortSelectN,
   input wire readPortSelectN,
   input wire rdValid,
   input wire rdReady,
   input wire [DATA_W-1:0] rdData,
   input wire writeBusy,
   input wire readBusy
);
   logic [3:0] wh;
   logic [3:0] rh;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // select history, so a start can be traced back through the synchroniser
   always @(posedge clk) begin
      wh <= {wh[2:0], writePortSelectN};
      rh <= {rh[2:0], readPortSelectN};
   end
   sequence s_rs; $rose(readBusy); endsequence
   sequence s_hold; rdValid && !rdReady; endsequence
   property p_wpl; writeBusy |=> !writeBusy; endproperty
   a_wpl: assert property (p_wpl) else $error("write start twice in a row");
   property p_wsel; writeBusy |-> !(&wh[3:2]); endproperty
   a_wsel: assert property (p_wsel) else $error("write while deselected");
   property p_rsel; s_rs |-> !(&rh[3:1]); endproperty
   a_rsel: assert property (p_rsel) else $error("read while deselected");
   property p_rv; s_rs |-> ##[0:3] rdValid; endproperty
   a_rv: assert property (p_rv) else $error("read word late");
   property p_hold; s_hold |=> rdValid && $stable(rdData); endproperty
   a_hold: assert property (p_hold) else $error("word lost in stall");
   property p_ref; s_rs |-> !writeBusy; endproperty
   a_ref: assert property (p_ref) else $error("read beside write start");
   property p_vc; $rose(rdValid) |-> readBusy; endproperty
   a_vc: assert property (p_vc) else $error("word without read");
   property p_rb; s_rs |=> readBusy [*3]; endproperty
   a_rb: assert property (p_rb) else $error("burst cut short");
endmodule
bind dsw_write_port dsw_chk #(.DATA_W(DATA_W)) dsw_chk_inst (.*);

// ---- bench/dsw_ctl_model.sv ----
// controller model driving select, address, beats and byte selects
`timescale 1ns/1ps
module dsw_ctl_model (
   input wire clk,
   output logic writePortSelectN = 1,
   output logic readPortSelectN = 1,
   output logic [16:0] addrIn = 0,
   output logic [35:0] dataRise = 0,
   output logic [35:0] dataFall = 0,
   output logic [3:0] byteSelRiseN = 0,
   output logic [3:0] byteSelFallN = 0
);
   // two cycles per burst, so writes can follow back to back
   task wr(input logic [16:0] a, input logic [35:0] d0, d1, d2, d3, input logic [15:0] s);
      @(negedge clk);
      writePortSelectN = 0;
      addrIn = a;
      {dataFall, dataRise} = {d1, d0};
      {byteSelFallN, byteSelRiseN} = s[7:0];
      @(negedge clk);
      writePortSelectN = 1;
      addrIn = ~a;
      {dataFall, dataRise} = {d3, d2};
      {byteSelFallN, byteSelRiseN} = s[15:8];
   endtask
   // released data lines flip rather than keep a stale copy
   task rd(input logic [16:0] a);
      @(negedge clk);
      {dataRise, dataFall} = ~{dataRise, dataFall};
      readPortSelectN = 0;
      addrIn = a;
      @(negedge clk);
      readPortSelectN = 1;
      addrIn = ~a;
   endtask
endmodule

// ---- bench/tb.sv ----
// self-checking bench: random bursts written, read back under stalls
`timescale 1ns/1ps
module tb;
   logic clk = 0;
   logic sys_rst = 1;
   logic rdReady = 0;
   wire writePortSelectN, readPortSelectN, rdValid, writeBusy, readBusy;
   wire [16:0] addrIn;
   wire [35:0] dataRise, dataFall, rdData;
   wire [3:0] byteSelRiseN, byteSelFallN;
   logic [35:0] mem [16][4];
   logic [31:0] r = 32'h84a2;
   int failures = 0;
   int cmp_count = 0;
   dsw_write_port dsw_write_port_inst (.clk, .sys_rst, .writePortSelectN,
      .readPortSelectN, .addrIn, .dataRise, .dataFall, .byteSelRiseN, .byteSelFallN,
      .rdValid, .rdReady, .rdData, .writeBusy, .readBusy);
   dsw_ctl_model dsw_ctl_model_inst (.clk, .writePortSelectN, .readPortSelectN,
      .addrIn, .dataRise, .dataFall, .byteSelRiseN, .byteSelFallN);
   initial forever #12.5 clk = ~clk;
   function automatic logic [31:0] rnd();
      r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
      return r;
   endfunction
   // only lanes whose select is low take the new beat
   function automatic logic [35:0] mg(input logic [35:0] o, d, input logic [3:0] s);
      mg = o;
      for (int i = 0; i < 4; i++) if (!s[i]) mg[i*9+:9] = d[i*9+:9];
   endfunction
   task chk(input logic [35:0] s, e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("Error %0t seen %h want %h", $time, s, e);
      end
   endtask
   task test_done();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] s);
      logic [35:0] d [4];
      for (int k = 0; k < 4; k++) begin
         d[k] = 36'(rnd()) ^ {rnd(), 4'h0};
         mem[a][k] = mg(mem[a][k], d[k], s[k*4+:4]);
      end
      dsw_ctl_model_inst.wr({13'h0, a}, d[0], d[1], d[2], d[3], s);
   endtask
   // pop four words with a randomly stalling sink, then expect the buffer empty
   task rd(input logic [3:0] a);
      int n;
      n = 0;
      dsw_ctl_model_inst.rd({13'h0, a});
      for (int i = 0; i < 60 && n < 4; i++) begin
         @(negedge clk);
         rdReady = ^rnd();
         if (rdValid === 1'b1 && rdReady) begin
            chk(rdData, mem[a][n]);
            n++;
         end
      end
      if (n < 4) begin
         failures++;
         test_done();
      end
      repeat (8) @(negedge clk);
      chk({35'h0, rdValid}, 36'h0);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      sys_rst = 0;
      for (int a = 0; a < 16; a++) wr(4'(a), 16'h0);
      wr(4'h5, 16'hffff);
      wr(4'h6, 16'h5a3c);
      for (int i = 0; i < 24; i++) wr(4'(rnd()), 16'(rnd()));
      repeat (6) @(negedge clk);
      for (int a = 0; a < 16; a++) rd(4'(a));
      test_done();
   end
endmodule
